// ### itd_pkg.sv
package itd_pkg;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [19:0] ITD_SEL_B_OFS  = 20'h4407D;
  localparam logic [19:0] ITD_SEL_A_OFS  = 20'h4407F;
  localparam logic [19:0] ITD_STAT_OFS   = 20'h44080;
  localparam logic [7:0]  ITD_SEL_RESET  = 8'h00;
  localparam logic [7:0]  ITD_SEL_MASK   = 8'h2F;
  localparam int          ITD_SEL_DMA    = 5;
  localparam int          ITD_SEL_FAST   = 3;
  localparam int          ITD_SEL_THR_HI = 2;
  localparam int          ITD_STAT_BUSY  = 0;
  localparam int          ITD_STAT_PEND  = 1;
  localparam logic [2:0]  ITD_LEVEL_TOP  = 3'h7;
  // ****************************************************************
  // Descriptor mode word and layout
  // ****************************************************************
  localparam int          ITD_M_SIZE     = 0;
  localparam int          ITD_M_MEMSRC   = 1;
  localparam int          ITD_M_UPDS     = 2;
  localparam int          ITD_M_UPDD     = 3;
  localparam int          ITD_M_OPER     = 4;
  localparam int          ITD_M_BRST     = 5;
  localparam int          ITD_M_INTE     = 6;
  localparam int          ITD_M_CHAIN    = 7;
  localparam int          ITD_M_CNT_LO   = 4;
  localparam int          ITD_M_MULT     = 15;
  localparam logic [2:0]  ITD_LEN_HALF   = 3'h2;
  localparam logic [2:0]  ITD_LEN_WORD   = 3'h4;
  localparam logic [31:0] ITD_OFS_COUNT  = 32'h00000002;
  localparam logic [31:0] ITD_OFS_FIELD  = 32'h00000004;
  // ****************************************************************
  // Engine states
  // ****************************************************************
  typedef enum logic [13:0] {
    ITD_IDLE  = 14'h0001,
    ITD_LDMOD = 14'h0002,
    ITD_LDCNT = 14'h0004,
    ITD_LDSRC = 14'h0008,
    ITD_LDOPR = 14'h0010,
    ITD_LDDST = 14'h0020,
    ITD_LDCHN = 14'h0040,
    ITD_LDIAD = 14'h0080,
    ITD_RDSRC = 14'h0100,
    ITD_RDOPR = 14'h0200,
    ITD_WRDST = 14'h0400,
    ITD_WBCNT = 14'h0800,
    ITD_WBSRC = 14'h1000,
    ITD_WBDST = 14'h2000
  } itd_state_e;
endpackage

// ### itd_dma_two.sv
`timescale 1ns/1ps
// Operation
// - Level-7 request starts DMA when dma select is 1 and fast select is 0.
// - Transfers: memory, immediate, memory plus memory, immediate plus memory.
// - Full 32-bit addresses reach both 64-Mbyte windows.
// - Non-incrementing source or destination address stays fixed all transaction.
// - Incrementing address steps by 1 for bytes, 2 for halfwords.
// - Single mode performs one data transfer per accepted request.
// - Burst mode repeats transfers until the counter is exhausted.
// - Multiple mode moves several pairs, each with own source and destination.
// - Chain mode loads the next descriptor from the chain base and continues.
// - Completion interrupt pulses when the counter reaches zero, if enabled.
// - A halfword at the top address wraps its second byte to zero.
// - Wake-up only for a request level above the threshold field.
// - Fast select makes the level-7 request the fast interrupt.
// - DMA start ignores the CPU interrupt flag and processor priority.
// - Unimplemented selection bits are written zero; they read zero here.
// - Descriptor opens with a two-byte mode word.
// - Two-byte transfer count follows the mode word.
// - Immediate source uses only the low two bytes.
// - Chain base field gives the next descriptor start address.
module itd_dma_two
  import itd_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic [19:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        req_valid,
  input  wire logic [2:0]  req_level,
  input  wire logic [31:0] req_desc_base,
  output logic             fast_irq,
  output logic             normal_irq,
  output logic             wake_req,
  output logic             done_irq,
  output logic      [31:0] done_handler,
  output logic             chain_base_we,
  output logic      [31:0] chain_base,
  output logic      [31:0] mem_addr,
  output logic      [7:0]  mem_wdata,
  output logic             mem_rd,
  output logic             mem_wr,
  input  wire logic [7:0]  mem_rdata,
  input  wire logic        mem_ready
);
  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    itd_state_e  st;
    logic [7:0]  sel_a;
    logic [7:0]  sel_b;
    logic [7:0]  rdata;
    logic        pend;
    logic [31:0] pbase;
    logic [31:0] base;
    logic [31:0] p;
    logic [15:0] mode;
    logic [15:0] cnt;
    logic [31:0] descriptor_source_field;
    logic [31:0] oadr;
    logic [31:0] descriptor_dest_field;
    logic [31:0] descriptor_chain_base;
    logic [31:0] iadr;
    logic [15:0] sdat;
    logic [15:0] odat;
    logic [31:0] sh;
    logic [1:0]  bcnt;
    logic [2:0]  mk;
    logic [31:0] maddr;
    logic [7:0]  mwdata;
    logic        mrd;
    logic        mwr;
    logic        fast;
    logic        norm;
    logic        wake;
    logic        done;
    logic        cbwe;
  } itd_regs_s;

  itd_regs_s q_r;
  itd_regs_s q_nxt;

  function automatic itd_state_e data_start(input logic [15:0] m);
    if (m[ITD_M_MEMSRC]) begin
      return ITD_RDSRC;
    end
    return m[ITD_M_OPER] ? ITD_RDOPR : ITD_WRDST;
  endfunction

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    logic        dma_en;
    logic        mult;
    logic        is_wr;
    logic        last;
    logic [2:0]  len;
    logic [31:0] addr;
    logic [31:0] wsel;
    logic [31:0] shn;
    logic [31:0] v;
    logic [31:0] inc;
    logic [15:0] res;
    q_nxt = q_r;
    q_nxt.fast = 1'b0;
    q_nxt.norm = 1'b0;
    q_nxt.wake = 1'b0;
    q_nxt.done = 1'b0;
    q_nxt.cbwe = 1'b0;
    dma_en = q_r.sel_a[ITD_SEL_DMA] & ~q_r.sel_a[ITD_SEL_FAST];
    mult = q_r.mode[ITD_M_MULT];
    inc = q_r.mode[ITD_M_SIZE] ? 32'h00000002 : 32'h00000001;
    res = q_r.mode[ITD_M_OPER] && !mult ? q_r.sdat + q_r.odat : q_r.sdat;
    // Reserved selection bits are dropped on write and so read back as zero.
    // reserved bits masked
    if (reg_wr && reg_addr == ITD_SEL_A_OFS) begin
      q_nxt.sel_a = reg_wdata & ITD_SEL_MASK;
    end
    if (reg_wr && reg_addr == ITD_SEL_B_OFS) begin
      q_nxt.sel_b = reg_wdata & ITD_SEL_MASK;
    end
    q_nxt.rdata = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        ITD_SEL_A_OFS: q_nxt.rdata = q_r.sel_a;
        ITD_SEL_B_OFS: q_nxt.rdata = q_r.sel_b;
        ITD_STAT_OFS: begin
          q_nxt.rdata[ITD_STAT_BUSY] = q_r.st != ITD_IDLE;
          q_nxt.rdata[ITD_STAT_PEND] = q_r.pend;
        end
        default: q_nxt.rdata = 8'h00;
      endcase
    end
    // Engine takes the pending request first so that a new one in the same cycle survives.
    if (q_r.st == ITD_IDLE && q_r.pend) begin
      q_nxt.pend = 1'b0;
      q_nxt.base = q_r.pbase;
      q_nxt.p = q_r.pbase;
      q_nxt.st = ITD_LDMOD;
    end
    if (req_valid) begin
      q_nxt.wake = req_level > q_r.sel_a[ITD_SEL_THR_HI:0];
      if (req_level == ITD_LEVEL_TOP && dma_en) begin
        // Requests are not counted; a second one while pending is merged.
        // level 7 to DMA
        q_nxt.pend = 1'b1;
        q_nxt.pbase = req_desc_base;
      end else if (req_level == ITD_LEVEL_TOP && q_r.sel_a[ITD_SEL_FAST]) begin
        q_nxt.fast = 1'b1;
      end else begin
        q_nxt.norm = 1'b1;
      end
    end
    // ****************************************************************
    // Byte-serial memory engine
    // ****************************************************************
    unique case (q_r.st)
      ITD_LDMOD, ITD_LDCNT, ITD_WBCNT: len = ITD_LEN_HALF;
      ITD_RDSRC, ITD_RDOPR, ITD_WRDST: len = {1'b0, q_r.mode[ITD_M_SIZE], ~q_r.mode[ITD_M_SIZE]};
      default: len = ITD_LEN_WORD;
    endcase
    unique case (q_r.st)
      ITD_RDSRC: addr = q_r.descriptor_source_field + {30'h0, q_r.bcnt};
      ITD_RDOPR: addr = q_r.oadr + {30'h0, q_r.bcnt};
      ITD_WRDST: addr = q_r.descriptor_dest_field + {30'h0, q_r.bcnt};
      default: addr = q_r.p;
    endcase
    unique case (q_r.st)
      ITD_WBCNT: wsel = {16'h0, q_r.cnt};
      ITD_WBSRC: wsel = q_r.descriptor_source_field;
      ITD_WBDST: wsel = q_r.descriptor_dest_field;
      default: wsel = {16'h0, res};
    endcase
    wsel = wsel >> {q_r.bcnt, 3'h0};
    is_wr = q_r.st inside {ITD_WBCNT, ITD_WBSRC, ITD_WBDST, ITD_WRDST};
    last = {1'b0, q_r.bcnt} == len - 3'h1;
    shn = {mem_rdata, q_r.sh[31:8]};
    unique case (len)
      3'h1: v = {24'h0, shn[31:24]};
      3'h2: v = {16'h0, shn[31:16]};
      default: v = shn;
    endcase
    if (q_r.st != ITD_IDLE && !(q_r.mrd || q_r.mwr)) begin
      q_nxt.maddr = addr;
      q_nxt.mwdata = wsel[7:0];
      q_nxt.mrd = ~is_wr;
      q_nxt.mwr = is_wr;
    end else if (q_r.st != ITD_IDLE && mem_ready) begin
      q_nxt.mrd = 1'b0;
      q_nxt.mwr = 1'b0;
      q_nxt.sh = shn;
      q_nxt.bcnt = q_r.bcnt + 2'h1;
      if (!(q_r.st inside {ITD_RDSRC, ITD_RDOPR, ITD_WRDST})) begin
        q_nxt.p = q_r.p + 32'h00000001;
      end
      if (last) begin
        q_nxt.bcnt = 2'h0;
        unique case (q_r.st)
          ITD_LDMOD: begin
            q_nxt.mode = v[15:0];
            q_nxt.st = ITD_LDCNT;
          end
          ITD_LDCNT: begin
            q_nxt.cnt = v[15:0];
            q_nxt.mk = 3'h0;
            q_nxt.st = ITD_LDSRC;
          end
          ITD_LDSRC: begin
            q_nxt.descriptor_source_field = v;
            q_nxt.sdat = v[15:0];
            q_nxt.st = q_r.mode[ITD_M_OPER] && !mult ? ITD_LDOPR : ITD_LDDST;
          end
          ITD_LDOPR: begin
            q_nxt.oadr = v;
            q_nxt.st = ITD_LDDST;
          end
          ITD_LDDST: begin
            q_nxt.descriptor_dest_field = v;
            if (mult) begin
              q_nxt.st = ITD_RDSRC;
            end else if (q_r.mode[ITD_M_CHAIN]) begin
              q_nxt.st = ITD_LDCHN;
            end else if (q_r.mode[ITD_M_INTE]) begin
              q_nxt.st = ITD_LDIAD;
            end else begin
              q_nxt.st = data_start(q_r.mode);
            end
          end
          ITD_LDCHN: begin
            q_nxt.descriptor_chain_base = v;
            q_nxt.st = q_r.mode[ITD_M_INTE] ? ITD_LDIAD : data_start(q_r.mode);
          end
          ITD_LDIAD: begin
            q_nxt.iadr = v;
            q_nxt.st = data_start(q_r.mode);
          end
          ITD_RDSRC: begin
            q_nxt.sdat = v[15:0];
            q_nxt.st = q_r.mode[ITD_M_OPER] && !mult ? ITD_RDOPR : ITD_WRDST;
          end
          ITD_RDOPR: begin
            q_nxt.odat = v[15:0];
            q_nxt.st = ITD_WRDST;
          end
          ITD_WRDST: begin
            if (mult) begin
              q_nxt.mk = q_r.mk + 3'h1;
              q_nxt.st = q_nxt.mk == q_r.mode[ITD_M_CNT_LO+2:ITD_M_CNT_LO] ? ITD_IDLE : ITD_LDSRC;
            end else begin
              q_nxt.cnt = q_r.cnt - 16'h0001;
              if (q_r.mode[ITD_M_UPDS] && q_r.mode[ITD_M_MEMSRC]) begin
                q_nxt.descriptor_source_field = q_r.descriptor_source_field + inc;
              end
              if (q_r.mode[ITD_M_UPDD]) begin
                q_nxt.descriptor_dest_field = q_r.descriptor_dest_field + inc;
              end
              q_nxt.p = q_r.base + ITD_OFS_COUNT;
              q_nxt.st = ITD_WBCNT;
            end
          end
          ITD_WBCNT: q_nxt.st = ITD_WBSRC;
          ITD_WBSRC: begin
            if (q_r.mode[ITD_M_OPER]) begin
              q_nxt.p = q_r.p + 32'h00000001 + ITD_OFS_FIELD;
            end
            q_nxt.st = ITD_WBDST;
          end
          ITD_WBDST: begin
            if (q_r.cnt == 16'h0000) begin
              q_nxt.done = q_r.mode[ITD_M_INTE];
              q_nxt.st = ITD_IDLE;
              if (q_r.mode[ITD_M_CHAIN]) begin
                q_nxt.base = q_r.descriptor_chain_base;
                q_nxt.p = q_r.descriptor_chain_base;
                q_nxt.cbwe = 1'b1;
                q_nxt.st = ITD_LDMOD;
              end
            end else if (q_r.mode[ITD_M_BRST]) begin
              q_nxt.st = data_start(q_r.mode);
            end else begin
              q_nxt.st = ITD_IDLE;
            end
          end
          default: q_nxt.st = ITD_IDLE;
        endcase
      end
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      q_r <= '{st: ITD_IDLE, sel_a: ITD_SEL_RESET, sel_b: ITD_SEL_RESET, default: '0};
    end else begin
      q_r <= q_nxt;
    end
  end

  assign reg_rdata     = q_r.rdata;
  assign fast_irq      = q_r.fast;
  assign normal_irq    = q_r.norm;
  assign wake_req      = q_r.wake;
  assign done_irq      = q_r.done;
  assign done_handler  = q_r.iadr;
  assign chain_base_we = q_r.cbwe;
  assign chain_base    = q_r.descriptor_chain_base;
  assign mem_addr      = q_r.maddr;
  assign mem_wdata     = q_r.mwdata;
  assign mem_rd        = q_r.mrd;
  assign mem_wr        = q_r.mwr;
endmodule // itd_dma_two

// ### itd_dma_two_checker.sv
`timescale 1ns/1ps
module itd_dma_two_checker
  import itd_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic [19:0] reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic        req_valid,
  input wire logic [2:0]  req_level,
  input wire logic [31:0] req_desc_base,
  input wire logic        fast_irq,
  input wire logic        normal_irq,
  input wire logic        wake_req,
  input wire logic        done_irq,
  input wire logic [31:0] mem_addr,
  input wire logic        mem_rd,
  input wire logic        mem_wr,
  input wire logic        mem_ready
);
  // ****************************************************************
  // Shadow of copy A and an idle counter for the engine.
  // ****************************************************************
  logic [7:0] sel_r;
  logic [2:0] quiet_r;
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sel_r   <= ITD_SEL_RESET;
      quiet_r <= 3'h0;
    end else begin
      if (reg_wr && reg_addr == ITD_SEL_A_OFS) sel_r <= reg_wdata & ITD_SEL_MASK;
      if (mem_rd || mem_wr || req_valid) quiet_r <= 3'h0;
      else if (quiet_r != 3'h7) quiet_r <= quiet_r + 3'h1;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence s_dma_req;
    req_valid && req_level == ITD_LEVEL_TOP && sel_r[ITD_SEL_DMA] && !sel_r[ITD_SEL_FAST];
  endsequence
  sequence s_first_fetch;
    ##3 (mem_rd && mem_addr == $past(req_desc_base, 3));
  endsequence
  a_dma_no_cpu: assert property (s_dma_req |=> !fast_irq && !normal_irq)
    else $error("level 7 request reached the cpu while dma routing is on");
  a_dma_first_fetch: assert property (s_dma_req ##0 (quiet_r == 3'h7) |-> s_first_fetch)
    else $error("idle engine did not fetch the descriptor in three cycles");
  a_fast_route: assert property (req_valid && req_level == ITD_LEVEL_TOP && sel_r[ITD_SEL_FAST]
    |=> fast_irq && !normal_irq)
    else $error("level 7 request not serviced as fast interrupt");
  a_wake_above: assert property (req_valid && req_level > sel_r[2:0] |=> wake_req)
    else $error("no wake request for level above threshold");
  a_wake_below: assert property (!(req_valid && req_level > sel_r[2:0]) |=> !wake_req)
    else $error("wake request without a level above threshold");
  a_sel_read: assert property (reg_rd && reg_addr == ITD_SEL_A_OFS
    |=> reg_rdata == $past(sel_r))
    else $error("selection read differs from masked written value");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero outside the answer cycle");
  a_mem_hold: assert property ((mem_rd || mem_wr) && !mem_ready
    |=> $stable(mem_addr) && $stable(mem_rd) && $stable(mem_wr))
    else $error("memory request changed before ready");
  a_mem_one_strobe: assert property (!(mem_rd && mem_wr))
    else $error("memory read and write strobes together");
  a_done_pulse: assert property (done_irq |=> !done_irq)
    else $error("completion interrupt longer than one cycle");
endmodule // itd_dma_two_checker
bind itd_dma_two itd_dma_two_checker itd_dma_two_checker_i (.*);

// ### itd_mem_model.sv
`timescale 1ns/1ps
module itd_mem_model (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        slow,
  input  wire logic [31:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  output logic      [7:0]  mem_rdata,
  output logic             mem_ready
);
  // ****************************************************************
  // Byte memory; read data toggles when not valid so no stale byte passes.
  // ****************************************************************
  logic [7:0] mem [logic [31:0]];
  logic [1:0] wait_r;
  always @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      mem_ready <= 1'b0;
      mem_rdata <= 8'h00;
      wait_r    <= 2'h0;
    end else if ((mem_rd || mem_wr) && !mem_ready && wait_r == 2'h0) begin
      mem_ready <= 1'b1;
      mem_rdata <= mem_rd ? mem[mem_addr] : ~mem_rdata;
      if (mem_wr) mem[mem_addr] = mem_wdata;
    end else begin
      mem_ready <= 1'b0;
      mem_rdata <= ~mem_rdata;
      wait_r    <= (mem_rd || mem_wr) ? wait_r - 2'h1 : (slow ? 2'($urandom_range(2)) : 2'h0);
    end
  end
endmodule // itd_mem_model

// ### tb_itd_dma_two.sv
`timescale 1ns/1ps
module tb_itd_dma_two;
  import itd_pkg::*;
  logic        sys_clk, reset, reg_wr, reg_rd, req_valid, slow, rd_d, rq_d;
  logic        fast_irq, normal_irq, wake_req, done_irq, chain_base_we, mem_rd, mem_wr, mem_ready;
  logic [19:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, mem_wdata, mem_rdata;
  logic [2:0]  req_level;
  logic [31:0] req_desc_base, done_handler, chain_base, mem_addr;
  int          error_cnt, cmp_count, cyc, dones, chains;
  logic [7:0]  rd_q[$];
  logic [2:0]  ev_q[$];
  logic [39:0] wr_q[$];
  itd_dma_two itd_dma_two_i (.*);
  itd_mem_model itd_mem_model_i (.*);
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic finish_test;
    if (error_cnt == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [19:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    rd_q.push_back(e);
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
  endtask
  task automatic req(input logic [2:0] l, input logic [31:0] b, input logic [2:0] e);
    @(posedge sys_clk);
    req_valid     <= 1'b1;
    req_level     <= l;
    req_desc_base <= b;
    ev_q.push_back(e);
    @(posedge sys_clk);
    req_valid     <= 1'b0;
  endtask
  task automatic sel(input logic [7:0] v);
    wr(ITD_SEL_A_OFS, v);
    wr(ITD_SEL_B_OFS, v);
  endtask
  task automatic desc(input logic [31:0] b, input logic [15:0] m, input logic [15:0] c,
                      input logic [31:0] f[4]);
    for (int i = 0; i < 2; i++) begin
      itd_mem_model_i.mem[b + i]     = m[8*i +: 8];
      itd_mem_model_i.mem[b + 2 + i] = c[8*i +: 8];
    end
    for (int j = 0; j < 16; j++) begin
      itd_mem_model_i.mem[b + 4 + j] = f[j/4][8*(j%4) +: 8];
    end
  endtask
  task automatic wait_idle;
    int q;
    q = 0;
    while (q < 8) begin
      @(posedge sys_clk);
      q = (mem_rd || mem_wr) ? 0 : q + 1;
    end
  endtask
  task automatic run(input logic [31:0] b);
    req(ITD_LEVEL_TOP, b, 3'b001);
    wait_idle();
  endtask
  // ****************************************************************
  // Result watcher
  // ****************************************************************
  always @(posedge sys_clk) begin
    rd_d <= reg_rd;
    rq_d <= req_valid;
    if (rd_d) chk(reg_rdata, rd_q.pop_front());
    if (rq_d) chk({fast_irq, normal_irq, wake_req}, ev_q.pop_front());
    if (mem_wr && mem_ready && mem_addr[31:8] != 24'h4) chk({mem_addr, mem_wdata}, wr_q.pop_front());
    if (done_irq) dones++;
    if (chain_base_we) chains++;
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      finish_test();
    end
  end
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial begin
    logic [7:0] s;
    logic [7:0] b;
    {reset, reg_wr, reg_rd, req_valid, slow} <= 5'h10;
    {reg_addr, reg_wdata, req_level, req_desc_base} <= '0;
    void'($urandom(32'hD88C));
    repeat (20) @(posedge sys_clk);
    reset <= 1'b0;
    rd(ITD_SEL_A_OFS, 8'h00);
    rd(ITD_STAT_OFS, 8'h00);
    wr(ITD_SEL_B_OFS, 8'hD7);
    rd(ITD_SEL_B_OFS, 8'h07);
    rd(20'h44081, 8'h00);
    desc(32'h400, 16'h0000, 16'h0001, '{32'hABCD0011, 32'h3000, 32'h0, 32'h0});
    for (int k = 0; k < 3; k++) begin
      s = {2'b00, k == 2, 1'b0, k == 1, 3'($urandom_range(7))};
      sel(s);
      for (int l = 0; l < 8; l++) begin
        if (l == 7 && k == 2) wr_q.push_back({32'h3000, 8'h11});
        req(3'(l), 32'h400, {l == 7 && k == 1, l != 7 || k == 0, 3'(l) > s[2:0]});
        wait_idle();
      end
    end
    slow <= 1'b1;
    sel(8'h20);
    desc(32'h440, 16'h006F, 16'h0003, '{32'h01FFFFF0, 32'hFE000100, 32'h0000ABC0, 32'h0});
    for (int i = 0; i < 6; i++) begin
      b = 8'($urandom);
      itd_mem_model_i.mem[32'h01FFFFF0 + i] = b;
      wr_q.push_back({32'hFE000100 + i, b});
    end
    dones = 0;
    run(32'h440);
    chk(dones, 1);
    chk(done_handler, 32'h0000ABC0);
    chk({itd_mem_model_i.mem[32'h443], itd_mem_model_i.mem[32'h442]}, 16'h0000);
    chk({itd_mem_model_i.mem[32'h447], itd_mem_model_i.mem[32'h446],
         itd_mem_model_i.mem[32'h445], itd_mem_model_i.mem[32'h444]}, 32'h01FFFFF6);
    desc(32'h480, 16'h0000, 16'h0002, '{32'h5A5A00C3, 32'h2000, 32'h0, 32'h0});
    for (int i = 0; i < 2; i++) begin
      wr_q.push_back({32'h2000, 8'hC3});
      run(32'h480);
      chk(itd_mem_model_i.mem[32'h482], 8'(1 - i));
    end
    for (int i = 0; i < 2; i++) begin
      itd_mem_model_i.mem[32'hFFFFFFFF] = 8'h34;
      itd_mem_model_i.mem[32'h0] = 8'h12;
      itd_mem_model_i.mem[32'hFE000010] = 8'h0F;
      itd_mem_model_i.mem[32'hFE000011] = 8'h0F;
      desc(32'h4C0, 16'h0011 | 16'(2 * i), 16'h0001,
           '{i ? 32'hFFFFFFFF : 32'hFFFF1234, 32'hFE000010, 32'hFFFFFFFF, 32'h0});
      wr_q.push_back({32'hFFFFFFFF, 8'h43});
      wr_q.push_back({32'h00000000, 8'h21});
      run(32'h4C0);
    end
    desc(32'h4E0, 16'h0080, 16'h0001, '{32'h77, 32'h2100, 32'h480, 32'h0});
    desc(32'h480, 16'h0000, 16'h0001, '{32'h88, 32'h2101, 32'h0, 32'h0});
    wr_q.push_back({32'h2100, 8'h77});
    wr_q.push_back({32'h2101, 8'h88});
    run(32'h4E0);
    chk(chain_base, 32'h480);
    chk(chains, 1);
    desc(32'h4A0, 16'h8022, 16'h0001, '{32'h3100, 32'h3200, 32'h3101, 32'h3201});
    itd_mem_model_i.mem[32'h3100] = 8'h5C;
    itd_mem_model_i.mem[32'h3101] = 8'hA3;
    wr_q.push_back({32'h3200, 8'h5C});
    wr_q.push_back({32'h3201, 8'hA3});
    run(32'h4A0);
    chk(wr_q.size(), 0);
    finish_test();
  end
endmodule // tb_itd_dma_two
